//--- design/dcwg_map.vh
// Register map, field positions, reset values and AXI responses of the waveform generator
`ifndef DCWG_MAP_VH
`define DCWG_MAP_VH

`define DCWG_AXI_AW 8
`define DCWG_NUM_REGS 20
`define DCWG_NUM_CFG 19
`define DCWG_PINS 7

// Word offsets (byte address = offset)
`define DCWG_OFS_CTRL 8'h00
`define DCWG_OFS_RATIO 8'h04
`define DCWG_OFS_PCLK 8'h08
`define DCWG_OFS_LINE 8'h0c
`define DCWG_OFS_ASYNC 8'h10
`define DCWG_OFS_SYNC0 8'h14
`define DCWG_OFS_ASPIN0 8'h30
`define DCWG_OFS_STATUS 8'h4c

// Word indices
`define DCWG_IDX_CTRL 5'd0
`define DCWG_IDX_RATIO 5'd1
`define DCWG_IDX_PCLK 5'd2
`define DCWG_IDX_LINE 5'd3
`define DCWG_IDX_ASYNC 5'd4
`define DCWG_IDX_SYNC0 5'd5
`define DCWG_IDX_ASPIN0 5'd12
`define DCWG_IDX_STATUS 5'd19

// Control bits
`define DCWG_CTRL_SYNC_EN 0
`define DCWG_CTRL_ASYNC_EN 1

// Pin generator word: up [9:0], down [25:16], trigger [29:28], invert [31]
`define DCWG_UP_LSB 0
`define DCWG_DN_LSB 16
`define DCWG_TRIG_LSB 28
`define DCWG_INV_BIT 31
`define DCWG_TRIG_PIXEL 2'h0
`define DCWG_TRIG_LINE 2'h1
`define DCWG_TRIG_FRAME 2'h2
`define DCWG_TRIG_OFF 2'h3

// Reset values
`define DCWG_RST_CTRL 32'h00000000
`define DCWG_RST_RATIO 32'h00000020
`define DCWG_RST_PCLK 32'h00020000
`define DCWG_RST_LINE 32'h00040004
`define DCWG_RST_ASYNC 32'h00000008
`define DCWG_RST_PIN 32'h30000000

// AXI responses
`define DCWG_RESP_OKAY 2'h0
`define DCWG_RESP_SLVERR 2'h2

`endif

//--- design/dcwg_waveform_gen.v
// Display control waveform generator with AXI4-Lite register access
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dcwg_map.vh"

// Notes on behaviour
// - Separate synchronous and asynchronous pin groups
// - Sync outputs repeat with fixed period, shape
// - Dedicated pixel clock output to display
// - Seven sync pins, each independently assignable
// - Linked counters make base-clock-aligned start points
// - Edges at programmed up/down from start
// - Async pins change with data, by flags
// - Two chip selects, one per panel
// - Seven async pins for strobes, select
// - Each new data item restarts async timing
// - Pixel clock edges offset in half-cycles
// - Sync edges offset in half-cycle units
// - Pixel period in sixteenths of base cycle
// - Fractional period alternates floor, floor plus one
// - Each generator programs up/down edges and invert; sync ones a trigger
// - Line syncs spaced by line length
module dcwg_waveform_gen (
	// Clock and reset; aclk is twice the interface base clock
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [`DCWG_AXI_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [`DCWG_AXI_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Asynchronous data items from the user side
	input wire async_valid,
	output reg async_ready,
	input wire [15:0] async_data,
	input wire [`DCWG_PINS-1:0] async_flags,
	input wire async_panel,
	// Synchronous display pins
	output reg pixel_clock_out,
	output reg [`DCWG_PINS-1:0] sync_pin,
	// Asynchronous display pins
	output reg [15:0] panel_data,
	output reg panel0_select_n,
	output reg panel1_select_n,
	output reg [`DCWG_PINS-1:0] async_pin
);

	reg [31:0] regs_reg [0:`DCWG_NUM_CFG-1];
	reg [`DCWG_AXI_AW-1:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg aw_have_reg;
	reg w_have_reg;
	reg [9:0] ph_cnt_reg;
	reg [9:0] ph_end_reg;
	reg [3:0] frac_reg;
	reg [11:0] pix_cnt_reg;
	reg [11:0] line_cnt_reg;
	reg pix_start_reg;
	reg line_start_reg;
	reg frame_start_reg;
	reg [7:0] item_cnt_reg;
	reg busy_reg;
	reg [`DCWG_PINS-1:0] flags_reg;
	reg panel_reg;

	wire sync_en = regs_reg[`DCWG_IDX_CTRL][`DCWG_CTRL_SYNC_EN];
	wire async_en = regs_reg[`DCWG_IDX_CTRL][`DCWG_CTRL_ASYNC_EN];
	wire [15:0] ratio = regs_reg[`DCWG_IDX_RATIO][15:0];
	wire [31:0] pclk_cfg = regs_reg[`DCWG_IDX_PCLK];
	wire [11:0] line_length = regs_reg[`DCWG_IDX_LINE][11:0];
	wire [11:0] frame_lines = regs_reg[`DCWG_IDX_LINE][27:16];
	wire [7:0] item_len = regs_reg[`DCWG_IDX_ASYNC][7:0];

	// Word index of a byte address, all ones when off the map
	function [4:0] reg_index;
		input [`DCWG_AXI_AW-1:0] addr;
		input is_read;
		begin
			reg_index = 5'h1f;
			if (addr[1:0] == 2'h0) begin
				if (addr[6:2] < `DCWG_NUM_CFG)
					reg_index = addr[6:2];
				else if (is_read && addr[6:2] == `DCWG_IDX_STATUS)
					reg_index = addr[6:2];
			end
			if (addr[7])
				reg_index = 5'h1f;
		end
	endfunction

	// Byte-lane merge of a write
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b])
					merge[b*8 +: 8] = data[b*8 +: 8];
			end
		end
	endfunction

	wire [4:0] wr_idx = reg_index(awaddr_reg, 1'b0);
	wire [4:0] rd_idx = reg_index(s_axi_araddr, 1'b1);
	wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

	// Write channels, taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= {`DCWG_AXI_AW{1'b0}};
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DCWG_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			// Held low while a response is pending
			s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) && !do_write &&
				!s_axi_bvalid;
			s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) && !do_write &&
				!s_axi_bvalid;
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_idx == 5'h1f) ? `DCWG_RESP_SLVERR : `DCWG_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Configuration words
	genvar gi;
	generate
		for (gi = 0; gi < `DCWG_NUM_CFG; gi = gi + 1) begin : g_cfg
			always @(posedge aclk) begin
				if (!aresetn) begin
					if (gi == `DCWG_IDX_CTRL)
						regs_reg[gi] <= `DCWG_RST_CTRL;
					else if (gi == `DCWG_IDX_RATIO)
						regs_reg[gi] <= `DCWG_RST_RATIO;
					else if (gi == `DCWG_IDX_PCLK)
						regs_reg[gi] <= `DCWG_RST_PCLK;
					else if (gi == `DCWG_IDX_LINE)
						regs_reg[gi] <= `DCWG_RST_LINE;
					else if (gi == `DCWG_IDX_ASYNC)
						regs_reg[gi] <= `DCWG_RST_ASYNC;
					else
						regs_reg[gi] <= `DCWG_RST_PIN;
				end else if (do_write && wr_idx == gi) begin
					regs_reg[gi] <= merge(regs_reg[gi], wdata_reg, wstrb_reg);
				end
			end
		end
	endgenerate

	// Read channel, answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `DCWG_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `DCWG_RESP_OKAY;
				if (rd_idx == 5'h1f) begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `DCWG_RESP_SLVERR;
				end else if (rd_idx == `DCWG_IDX_STATUS)
					s_axi_rdata <= {busy_reg, 3'h0, line_cnt_reg, 4'h0, pix_cnt_reg};
				else
					s_axi_rdata <= regs_reg[rd_idx];
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	wire [16:0] ratio_sum = {13'h0000, frac_reg} + {1'b0, ratio};
	wire [11:0] base_len = (ratio_sum[16:4] == 13'h0000) ? 12'h001 : ratio_sum[15:4];
	wire ph_wrap = (ph_cnt_reg == ph_end_reg);
	wire pix_last = (pix_cnt_reg >= line_length - 12'h001);
	wire line_last = (line_cnt_reg >= frame_lines - 12'h001);

	// Linked pixel, line and frame counters
	always @(posedge aclk) begin
		if (!aresetn || !sync_en) begin
			ph_cnt_reg <= 10'h000;
			ph_end_reg <= 10'h000;
			frac_reg <= 4'h0;
			pix_cnt_reg <= 12'h000;
			line_cnt_reg <= 12'h000;
			pix_start_reg <= 1'b0;
			line_start_reg <= 1'b0;
			frame_start_reg <= 1'b0;
		end else begin
			pix_start_reg <= ph_wrap;
			line_start_reg <= ph_wrap && pix_last;
			frame_start_reg <= ph_wrap && pix_last && line_last;
			if (ph_wrap) begin
				ph_cnt_reg <= 10'h000;
				ph_end_reg <= {base_len[8:0], 1'b0} - 10'h001;
				frac_reg <= ratio_sum[3:0];
				if (pix_last) begin
					pix_cnt_reg <= 12'h000;
					line_cnt_reg <= line_last ? 12'h000 : line_cnt_reg + 12'h001;
				end else begin
					pix_cnt_reg <= pix_cnt_reg + 12'h001;
				end
			end else begin
				ph_cnt_reg <= ph_cnt_reg + 10'h001;
			end
		end
	end

	// Pixel clock edges from period start
	always @(posedge aclk) begin
		if (!aresetn || !sync_en)
			pixel_clock_out <= pclk_cfg[`DCWG_INV_BIT];
		else if (ph_cnt_reg == pclk_cfg[`DCWG_UP_LSB +: 10])
			pixel_clock_out <= !pclk_cfg[`DCWG_INV_BIT];
		else if (ph_cnt_reg == pclk_cfg[`DCWG_DN_LSB +: 10])
			pixel_clock_out <= pclk_cfg[`DCWG_INV_BIT];
	end

	generate
		for (gi = 0; gi < `DCWG_PINS; gi = gi + 1) begin : g_sync
			wire [31:0] cfg = regs_reg[`DCWG_IDX_SYNC0 + gi];
			wire [1:0] trig_sel = cfg[`DCWG_TRIG_LSB +: 2];
			wire trig = (trig_sel == `DCWG_TRIG_PIXEL) ? pix_start_reg :
				(trig_sel == `DCWG_TRIG_LINE) ? line_start_reg :
				(trig_sel == `DCWG_TRIG_FRAME) ? frame_start_reg : 1'b0;
			reg [9:0] cnt_reg;
			always @(posedge aclk) begin
				if (!aresetn || !sync_en)
					cnt_reg <= 10'h3ff;
				else if (trig)
					cnt_reg <= 10'h000;
				else if (cnt_reg != 10'h3ff)
					cnt_reg <= cnt_reg + 10'h001;
			end
			always @(posedge aclk) begin
				if (!aresetn || !sync_en || trig_sel == `DCWG_TRIG_OFF)
					sync_pin[gi] <= cfg[`DCWG_INV_BIT];
				else if (cnt_reg == cfg[`DCWG_UP_LSB +: 10])
					sync_pin[gi] <= !cfg[`DCWG_INV_BIT];
				else if (cnt_reg == cfg[`DCWG_DN_LSB +: 10])
					sync_pin[gi] <= cfg[`DCWG_INV_BIT];
			end
		end
	endgenerate

	wire accept = async_valid && async_ready;
	wire item_done = busy_reg && ((item_len == 8'h00) || (item_cnt_reg >= item_len - 8'h01));
	wire busy_next = accept || (busy_reg && !item_done);

	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg <= 1'b0;
			item_cnt_reg <= 8'h00;
			flags_reg <= {`DCWG_PINS{1'b0}};
			panel_reg <= 1'b0;
			panel_data <= 16'h0000;
			async_ready <= 1'b0;
		end else begin
			busy_reg <= busy_next;
			async_ready <= async_en && !busy_next;
			if (accept) begin
				item_cnt_reg <= 8'h00;
				flags_reg <= async_flags;
				panel_reg <= async_panel;
				panel_data <= async_data;
			end else if (busy_reg) begin
				item_cnt_reg <= item_cnt_reg + 8'h01;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			panel0_select_n <= 1'b1;
			panel1_select_n <= 1'b1;
		end else begin
			panel0_select_n <= !(busy_next && (accept ? !async_panel : !panel_reg));
			panel1_select_n <= !(busy_next && (accept ? async_panel : panel_reg));
		end
	end

	generate
		for (gi = 0; gi < `DCWG_PINS; gi = gi + 1) begin : g_async
			wire [31:0] cfg = regs_reg[`DCWG_IDX_ASPIN0 + gi];
			wire [9:0] pos = {2'h0, item_cnt_reg};
			always @(posedge aclk) begin
				if (!aresetn || !busy_reg || !flags_reg[gi])
					async_pin[gi] <= cfg[`DCWG_INV_BIT];
				else if (pos == cfg[`DCWG_UP_LSB +: 10])
					async_pin[gi] <= !cfg[`DCWG_INV_BIT];
				else if (pos == cfg[`DCWG_DN_LSB +: 10])
					async_pin[gi] <= cfg[`DCWG_INV_BIT];
			end
		end
	endgenerate

endmodule

//--- bench/dcwg_panel_model.sv
// Panel model: latches the data word on each write strobe rise while that panel's select is low
`timescale 1ns/1ps
module dcwg_panel_model (
	// Pins from the block
	input wire aclk,
	input wire [15:0] panel_data,
	input wire panel0_select_n,
	input wire panel1_select_n,
	input wire write_strobe,
	// Captured state
	output logic [15:0] last0,
	output logic [15:0] last1,
	output int cnt0,
	output int cnt1
);
	logic strobe_reg = 1'b0;
	initial begin
		last0 = 16'h0000;
		last1 = 16'h0000;
		cnt0 = 0;
		cnt1 = 0;
	end
	always @(posedge aclk) begin
		strobe_reg <= write_strobe;
		if (write_strobe && !strobe_reg && !panel0_select_n) begin
			last0 <= panel_data;
			cnt0 <= cnt0 + 1;
		end
		if (write_strobe && !strobe_reg && !panel1_select_n) begin
			last1 <= panel_data;
			cnt1 <= cnt1 + 1;
		end
	end
endmodule

//--- bench/dcwg_monitor.sv
// Protocol and pin checks for the waveform generator
`timescale 1ns/1ps
module dcwg_monitor (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// Async items and pins
	input wire async_valid,
	input wire async_ready,
	input wire [15:0] async_data,
	input wire async_panel,
	input wire [15:0] panel_data,
	input wire panel0_select_n,
	input wire panel1_select_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence item_taken;
		async_valid && async_ready;
	endsequence
	wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	wr_gap_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed");
	rd_gap_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during data");
	item_start_a: assert property (item_taken |=> !async_ready &&
		panel_data == $past(async_data) &&
		($past(async_panel) ? !panel1_select_n : !panel0_select_n))
		else $error("async item start wrong");
	one_panel_a: assert property (panel0_select_n || panel1_select_n)
		else $error("both selects active");
endmodule
bind dcwg_waveform_gen dcwg_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.async_valid(async_valid), .async_ready(async_ready), .async_data(async_data),
	.async_panel(async_panel), .panel_data(panel_data),
	.panel0_select_n(panel0_select_n), .panel1_select_n(panel1_select_n));

//--- bench/dcwg_waveform_gen_tb.sv
// Testbench for the display control waveform generator
`timescale 1ns/1ps
`include "dcwg_map.vh"
module dcwg_waveform_gen_tb;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic async_valid = 0, async_panel = 0;
	logic [15:0] async_data = 0;
	logic [6:0] async_flags = 0;
	wire awready, wready, bvalid, arready, rvalid, async_ready, pclk, sel0_n, sel1_n;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] panel_data, last0, last1;
	wire [6:0] sync_pin, async_pin;
	wire [2:0] probe = {sync_pin[1], sync_pin[0], pclk};
	int cnt0, cnt1;
	int miscompares = 0, checks_done = 0, cycles = 0;
	logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h30};
	logic [31:0] rv [7] = '{`DCWG_RST_CTRL, `DCWG_RST_RATIO, `DCWG_RST_PCLK, `DCWG_RST_LINE,
		`DCWG_RST_ASYNC, `DCWG_RST_PIN, `DCWG_RST_PIN};
	dcwg_waveform_gen u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.async_valid(async_valid), .async_ready(async_ready), .async_data(async_data),
		.async_flags(async_flags), .async_panel(async_panel), .pixel_clock_out(pclk),
		.sync_pin(sync_pin), .panel_data(panel_data), .panel0_select_n(sel0_n),
		.panel1_select_n(sel1_n), .async_pin(async_pin));
	dcwg_panel_model u_panel (.aclk(aclk), .panel_data(panel_data), .panel0_select_n(sel0_n),
		.panel1_select_n(sel1_n), .write_strobe(async_pin[0]), .last0(last0), .last1(last1),
		.cnt0(cnt0), .cnt1(cnt1));
	initial forever #4 aclk = ~aclk;
	task print_verdict;
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		bready <= 1;
		@(posedge aclk);
		bready <= 0;
		chk(bresp, er);
	endtask
	task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		rready <= 1;
		@(posedge aclk);
		rready <= 0;
		chk(rdata, ed);
		chk(rresp, er);
	endtask
	// Cycles and high cycles over np periods of a probe
	task meas(input int i, input int np, input int ep, input int eh);
		int c, h, r;
		logic p;
		c = 0;
		h = 0;
		r = 0;
		p = 1;
		@(negedge aclk);
		while (probe[i] !== 1'b0) @(negedge aclk);
		while (probe[i] !== 1'b1) @(negedge aclk);
		while (r < np) begin
			if (probe[i] === 1'b1) h++;
			@(negedge aclk);
			c++;
			if (probe[i] === 1'b1 && !p) r++;
			p = probe[i];
		end
		chk(c, ep);
		chk(h, eh);
	endtask
	task send(input logic [15:0] d, input logic [6:0] f, input logic p);
		@(posedge aclk);
		async_valid <= 1;
		async_data <= d;
		async_flags <= f;
		async_panel <= p;
		do @(posedge aclk); while (!async_ready);
		async_valid <= 0;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict;
		end
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		for (int k = 0; k < 7; k++) axi_rd(ra[k], rv[k], `DCWG_RESP_OKAY);
		axi_rd(8'h50, 32'h00000000, `DCWG_RESP_SLVERR);
		axi_wr(`DCWG_OFS_STATUS, 32'h00000001, `DCWG_RESP_SLVERR);
		axi_wr(8'h06, 32'h00000001, `DCWG_RESP_SLVERR);
		axi_wr(`DCWG_OFS_CTRL, 32'h00000003, `DCWG_RESP_OKAY);
		meas(0, 4, 16, 8);
		axi_wr(`DCWG_OFS_SYNC0, 32'h10020000, `DCWG_RESP_OKAY);
		axi_wr(8'h18, 32'h20020000, `DCWG_RESP_OKAY);
		meas(1, 1, 16, 2);
		meas(2, 1, 64, 2);
		axi_wr(`DCWG_OFS_RATIO, 32'h00000028, `DCWG_RESP_OKAY);
		axi_rd(`DCWG_OFS_RATIO, 32'h00000028, `DCWG_RESP_OKAY);
		meas(0, 4, 20, 8);
		axi_wr(`DCWG_OFS_ASYNC, 32'h00000006, `DCWG_RESP_OKAY);
		axi_wr(`DCWG_OFS_ASPIN0, 32'h00030001, `DCWG_RESP_OKAY);
		send(16'h1234, 7'h01, 1'b0);
		send(16'hbeef, 7'h01, 1'b0);
		send(16'h5a5a, 7'h01, 1'b1);
		send(16'h7777, 7'h00, 1'b1);
		repeat (10) @(posedge aclk);
		chk(cnt0, 2);
		chk(last0, 16'hbeef);
		chk(cnt1, 1);
		chk(last1, 16'h5a5a);
		print_verdict;
	end
endmodule
